// File: framer_assertions.sv
// Checker for the serial packet framer, bound to its top module.
// Assumes clkEn is held high while the framer is checked.
`timescale 1ns/1ps
module framer_assertions (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Serial side
   input wire logic rxValid,
   input wire logic [7:0] rxData,
   input wire logic rxReady,
   // Frame side
   input wire logic txValid,
   input wire logic [7:0] txData,
   input wire logic txLast,
   input wire logic txReady,
   // Configuration
   input wire logic [10:0] packLength,
   input wire logic [7:0] delim1,
   input wire logic delim1En,
   input wire logic delim2En,
   input wire serial_packet_framer_pkg::delim_mode_type delimMode,
   input wire logic [15:0] flushTimeoutMs,
   input wire logic [15:0] listenPortNumber,
   input wire logic [3:0] maxConnections,
   input wire logic [15:0] localSerialCfg,
   input wire logic [15:0] hostSerialCfg,
   // Status
   input wire logic connClose,
   input wire logic [15:0] listenPort,
   input wire logic [15:0] activeSerialCfg,
   input wire logic [10:0] bufLevel
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // Accepting edges that must or must not start a release
   wire logic take = rxValid && rxReady;
   wire logic keepHit = take && delim1En && !delim2En && rxData == delim1
      && delimMode == serial_packet_framer_pkg::DELIM_KEEP;
   wire logic lenHit = take && packLength != 11'h000
      && bufLevel + 11'h001 == packLength;
   wire logic fullHit = take && bufLevel == 11'h3ff;
   wire logic quietTake = take && packLength == 11'h000 && !delim1En
      && !delim2En && flushTimeoutMs == 16'h0000 && bufLevel < 11'h3ff;
   // Values the registered outputs settle to one edge later
   wire logic [15:0] portPick = (listenPortNumber == 16'h0000) ?
      16'h0fa1 : listenPortNumber;
   wire logic [15:0] cfgPick = (maxConnections >= 4'h2) ?
      localSerialCfg : hostSerialCfg;
   // Intake stops first, then the first frame byte is offered
   sequence release_s;
      !rxReady ##[1:2] txValid;
   endsequence
   keep_release_a:
      assert property (keepHit |=> release_s) else $error("no keep release");
   length_release_a:
      assert property (lenHit |=> release_s) else $error("no length release");
   full_release_a:
      assert property (fullHit |=> release_s) else $error("no full release");
   no_release_a:
      assert property (quietTake |=> rxReady
         && bufLevel == $past(bufLevel) + 11'h001)
         else $error("early release");
   level_cap_a:
      assert property (bufLevel <= 11'h400) else $error("buffer over 1 KB");
   drain_hold_a:
      assert property (txValid |-> !rxReady) else $error("intake while draining");
   tx_stall_a:
      assert property (txValid && !txReady |=> txValid && $stable(txData)
         && $stable(txLast)) else $error("stalled byte changed");
   close_pulse_a:
      assert property (connClose |=> !connClose)
         else $error("close not a pulse");
   listen_port_a:
      assert property (1'b1 |=> listenPort == $past(portPick))
         else $error("listen port wrong");
   serial_cfg_a:
      assert property (1'b1 |=> activeSerialCfg == $past(cfgPick))
         else $error("serial settings source wrong");
endmodule

bind serial_packet_framer framer_assertions chk_u (.*);

// File: serial_packet_framer.sv
// Serial packet framer: gathers serial bytes into a 1 KB buffer and
// releases them as frames toward the network side.
// Assumes the byte source and frame sink run on clk; handshakes are
// valid/ready, and config ports are held steady by software.
`timescale 1ns/1ps
`include "serial_packet_framer_params.svh"
module serial_packet_framer #(
   parameter int CYCLES_PER_MS = `SPF_CYCLES_PER_MS,
   parameter int MS_PER_MIN = `SPF_MS_PER_MIN
) (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic resetn,
   input wire logic clkEn,
   // Serial byte input
   input wire logic rxValid,
   input wire logic [7:0] rxData,
   output logic rxReady,
   // Frame output
   output logic txValid,
   output logic [7:0] txData,
   output logic txLast,
   input wire logic txReady,
   // Framing configuration
   input wire logic [10:0] packLength,
   input wire logic [7:0] delim1,
   input wire logic delim1En,
   input wire logic [7:0] delim2,
   input wire logic delim2En,
   input wire serial_packet_framer_pkg::delim_mode_type delimMode,
   input wire logic [15:0] flushTimeoutMs,
   // Connection configuration and status
   input wire logic [6:0] connectionIdleCheck,
   input wire logic [15:0] listenPortNumber,
   input wire logic connOpen,
   input wire logic netActivity,
   output logic connClose,
   output logic [15:0] listenPort,
   // Serial parameter selection
   input wire logic [3:0] maxConnections,
   input wire logic [15:0] localSerialCfg,
   input wire logic [15:0] hostSerialCfg,
   output logic [15:0] activeSerialCfg,
   // Status
   output logic [10:0] bufLevel
);
   localparam int CW = `SPF_CNT_W;

   logic [7:0] mem [0:`SPF_BUF_DEPTH-1];
   serial_packet_framer_pkg::framer_state_type state_r, state_nxt;
   logic [CW-1:0] cnt_r, cnt_nxt;
   logic [CW-1:0] frameLen_r, frameLen_nxt;
   logic [CW-1:0] rdPtr_r, rdPtr_nxt;
   logic armed_r, armed_nxt;
   logic [1:0] trail_r, trail_nxt;
   logic [15:0] elapsed_r, elapsed_nxt;
   logic rxReady_r, rxReady_nxt;
   logic txValid_r, txValid_nxt;
   logic [7:0] txData_r, txData_nxt;
   logic txLast_r, txLast_nxt;
   logic wrEn;
   logic [CW-1:0] wrAddr;
   logic accept;
   logic msTick;
   logic minTick;

   assign accept = rxValid && rxReady_r;

   // Millisecond base, realigned on every accepted byte
   tick_divider #(.W(18)) msPrescaler (
      .clk(clk),
      .resetn(resetn),
      .clkEn(clkEn),
      .clear(accept),
      .step(1'b1),
      .limit(18'(CYCLES_PER_MS)),
      .tick(msTick)
   );

   // Minute base for the idle connection check, restarted by traffic
   tick_divider #(.W(16)) minPrescaler (
      .clk(clk),
      .resetn(resetn),
      .clkEn(clkEn),
      .clear(netActivity || !connOpen),
      .step(msTick),
      .limit(16'(MS_PER_MIN)),
      .tick(minTick)
   );

   // Framing decisions: delimiters, length, fill level, timeout
   always_comb begin
      logic match;
      logic store;
      logic flushNow;
      logic [CW-1:0] newCnt;
      match = 1'b0;
      store = 1'b1;
      flushNow = 1'b0;
      newCnt = cnt_r;
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      frameLen_nxt = frameLen_r;
      rdPtr_nxt = rdPtr_r;
      armed_nxt = armed_r;
      trail_nxt = trail_r;
      elapsed_nxt = elapsed_r;
      txValid_nxt = txValid_r;
      txData_nxt = txData_r;
      txLast_nxt = txLast_r;
      wrEn = 1'b0;
      wrAddr = cnt_r;
      case (state_r)
         serial_packet_framer_pkg::ST_COLLECT: begin
            if (accept) begin
               elapsed_nxt = '0;
               if (trail_r != 2'h0) begin
                  trail_nxt = trail_r - 2'h1;
                  flushNow = (trail_r == 2'h1);
               end else if (delim2En) begin
                  // Pair must arrive back to back: delim1 then delim2
                  match = armed_r && (rxData == delim2);
                  armed_nxt = !match && (rxData == delim1);
               end else begin
                  match = delim1En && (rxData == delim1);
               end
               if (match) begin
                  armed_nxt = 1'b0;
                  case (delimMode)
                     serial_packet_framer_pkg::DELIM_PLUS1:
                        trail_nxt = 2'h1;
                     serial_packet_framer_pkg::DELIM_PLUS2:
                        trail_nxt = 2'h2;
                     serial_packet_framer_pkg::DELIM_STRIP: begin
                        store = 1'b0;
                        flushNow = 1'b1;
                     end
                     default: flushNow = 1'b1;
                  endcase
               end
               if (store) begin
                  wrEn = 1'b1;
                  newCnt = cnt_r + CW'(1);
               end else if (delim2En) begin
                  newCnt = cnt_r - CW'(1);
               end
               // Zero length means only delimiters, timeouts and a full buffer flush
               if (packLength != 11'h000
                   && newCnt == packLength) begin
                  flushNow = 1'b1;
               end
               if (newCnt == `SPF_BUF_DEPTH) begin
                  flushNow = 1'b1;
               end
            end else if (flushTimeoutMs != 16'h0000 && cnt_r != '0
                         && msTick) begin
               elapsed_nxt = elapsed_r + 16'h0001;
               if (elapsed_nxt == flushTimeoutMs) begin
                  flushNow = 1'b1;
               end
            end
            // A frame stripped down to nothing is not sent
            if (newCnt == '0) begin
               flushNow = 1'b0;
            end
            cnt_nxt = newCnt;
            if (flushNow) begin
               state_nxt = serial_packet_framer_pkg::ST_DRAIN;
               frameLen_nxt = newCnt;
               rdPtr_nxt = '0;
               armed_nxt = 1'b0;
               trail_nxt = 2'h0;
               elapsed_nxt = '0;
            end
         end
         serial_packet_framer_pkg::ST_DRAIN: begin
            if (!txValid_r || txReady) begin
               if (rdPtr_r != frameLen_r) begin
                  txValid_nxt = 1'b1;
                  txData_nxt = mem[rdPtr_r[`SPF_ADDR_W-1:0]];
                  txLast_nxt = (rdPtr_r == frameLen_r - CW'(1));
                  rdPtr_nxt = rdPtr_r + CW'(1);
               end else begin
                  txValid_nxt = 1'b0;
                  txLast_nxt = 1'b0;
                  state_nxt = serial_packet_framer_pkg::ST_COLLECT;
                  cnt_nxt = '0;
               end
            end
         end
         default: begin
            state_nxt = serial_packet_framer_pkg::ST_COLLECT;
            cnt_nxt = '0;
         end
      endcase
      // Bytes wait at the source while a frame is emptied out
      rxReady_nxt = (state_nxt == serial_packet_framer_pkg::ST_COLLECT);
   end

   // Framer registers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= serial_packet_framer_pkg::ST_COLLECT;
         cnt_r <= '0;
         frameLen_r <= '0;
         rdPtr_r <= '0;
         armed_r <= 1'b0;
         trail_r <= 2'h0;
         elapsed_r <= '0;
         rxReady_r <= 1'b0;
         txValid_r <= 1'b0;
         txData_r <= 8'h00;
         txLast_r <= 1'b0;
      end else if (clkEn) begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         frameLen_r <= frameLen_nxt;
         rdPtr_r <= rdPtr_nxt;
         armed_r <= armed_nxt;
         trail_r <= trail_nxt;
         elapsed_r <= elapsed_nxt;
         rxReady_r <= rxReady_nxt;
         txValid_r <= txValid_nxt;
         txData_r <= txData_nxt;
         txLast_r <= txLast_nxt;
      end
   end

   // Buffer storage; no reset, contents are meaningful only below cnt_r
   always_ff @(posedge clk) begin
      if (clkEn && wrEn) begin
         mem[wrAddr[`SPF_ADDR_W-1:0]] <= rxData;
      end
   end

   // Connection housekeeping state
   logic [6:0] idleMin_r, idleMin_nxt;
   logic connClose_r, connClose_nxt;
   logic [15:0] listenPort_r, listenPort_nxt;
   logic [15:0] activeCfg_r, activeCfg_nxt;

   // Idle close, listen port and serial settings selection
   always_comb begin
      idleMin_nxt = idleMin_r;
      connClose_nxt = 1'b0;
      if (!connOpen || netActivity || connectionIdleCheck == 7'h00) begin
         idleMin_nxt = 7'h00;
      end else if (minTick) begin
         idleMin_nxt = idleMin_r + 7'h01;
         if (idleMin_nxt == connectionIdleCheck) begin
            connClose_nxt = 1'b1;
            idleMin_nxt = 7'h00;
         end
      end
      // Port zero is outside the legal range, so fall back to default
      if (listenPortNumber == 16'h0000) begin
         listenPort_nxt = `SPF_LISTEN_PORT_DEFAULT;
      end else begin
         listenPort_nxt = listenPortNumber;
      end
      if (maxConnections >= `SPF_MULTI_HOST_MIN) begin
         activeCfg_nxt = localSerialCfg;
      end else begin
         activeCfg_nxt = hostSerialCfg;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         idleMin_r <= 7'h00;
         connClose_r <= 1'b0;
         listenPort_r <= `SPF_LISTEN_PORT_DEFAULT;
         activeCfg_r <= 16'h0000;
      end else if (clkEn) begin
         idleMin_r <= idleMin_nxt;
         connClose_r <= connClose_nxt;
         listenPort_r <= listenPort_nxt;
         activeCfg_r <= activeCfg_nxt;
      end
   end

   // Outputs straight from flops
   assign rxReady = rxReady_r;
   assign txValid = txValid_r;
   assign txData = txData_r;
   assign txLast = txLast_r;
   assign connClose = connClose_r;
   assign listenPort = listenPort_r;
   assign activeSerialCfg = activeCfg_r;
   assign bufLevel = cnt_r;
endmodule

// File: serial_packet_framer_params.svh
// Constants for the serial packet framer: sizes, defaults, timing counts.
// Assumes a 200 MHz system clock; included by bare name.
`ifndef SERIAL_PACKET_FRAMER_PARAMS_SVH
`define SERIAL_PACKET_FRAMER_PARAMS_SVH

// Receive buffer, one per serial port
`define SPF_BUF_DEPTH 11'h400
`define SPF_ADDR_W 10
`define SPF_CNT_W 11

// Clock rate and time units
`define SPF_CLK_HZ 200000000
`define SPF_MS_PER_S 1000
`define SPF_CYCLES_PER_MS (`SPF_CLK_HZ / `SPF_MS_PER_S)
`define SPF_MS_PER_MIN 60000

// Software-facing defaults
`define SPF_LISTEN_PORT_DEFAULT 16'h0fa1
`define SPF_IDLE_CHECK_DEFAULT 7'h07
`define SPF_FLUSH_TIMEOUT_DEFAULT 16'h0000
`define SPF_MULTI_HOST_MIN 4'h2

`endif

// File: serial_packet_framer_pkg.sv
// Types shared by the serial packet framer files.
// Assumes nothing beyond a SystemVerilog compiler.
package serial_packet_framer_pkg;

   // Handling of a matched delimiter
   typedef enum logic [1:0] {
      DELIM_KEEP  = 2'b00,
      DELIM_PLUS1 = 2'b01,
      DELIM_PLUS2 = 2'b10,
      DELIM_STRIP = 2'b11
   } delim_mode_type;

   // Framer state: filling the buffer or emptying a frame out
   typedef enum logic {
      ST_COLLECT = 1'b0,
      ST_DRAIN   = 1'b1
   } framer_state_type;

endpackage

// File: serial_source.sv
// Model of the attached serial device: offers one byte at a time.
// Assumes its tasks are called just after a clk rising edge.
`timescale 1ns/1ps
module serial_source (
   // Clock
   input wire logic clk,
   // Byte handshake
   input wire logic rxReady,
   output logic rxValid,
   output logic [7:0] rxData
);
   // Quiet line at time zero
   initial begin
      rxValid = 1'b0;
      rxData = 8'h5a;
   end
   // Hold the byte until an edge that sees the framer ready
   task automatic put(input logic [7:0] b);
      rxValid <= 1'b1;
      rxData <= b;
      @(posedge clk iff rxReady);
   endtask
   // Idle gap; junk toggles so a stale byte is never mistaken for data
   task automatic rest(input int n);
      repeat (n) begin
         rxValid <= 1'b0;
         rxData <= ~rxData;
         @(posedge clk);
      end
   endtask
endmodule

// File: testbench.sv
// Self-checking bench for the serial packet framer.
// Assumes the framer, its bound checker and the serial device model.
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic clkEn = 1'b1;
   logic rxValid, rxReady, txValid, txLast, connClose;
   logic txReady = 1'b0;
   logic [7:0] rxData, txData;
   logic [10:0] packLength = 11'h000;
   logic [10:0] bufLevel;
   logic [7:0] delim1 = 8'h0d;
   logic [7:0] delim2 = 8'h0a;
   logic delim1En = 1'b1;
   logic delim2En = 1'b0;
   serial_packet_framer_pkg::delim_mode_type delimMode;
   logic [15:0] flushTimeoutMs = 16'h0000;
   logic [15:0] listenPortNumber = 16'h0000;
   logic [15:0] localSerialCfg = 16'h0000;
   logic [15:0] hostSerialCfg = 16'h0000;
   logic [15:0] activeSerialCfg, listenPort;
   logic [6:0] connectionIdleCheck = 7'h00;
   logic connOpen = 1'b0;
   logic netActivity = 1'b0;
   logic [3:0] maxConnections = 4'h1;
   logic [8:0] expQ[$];
   int mismatches = 0;
   int checked = 0;
   int cycles = 0;
   int closes = 0;

   serial_packet_framer #(.CYCLES_PER_MS(10), .MS_PER_MIN(5)) dut_u (.*);
   serial_source src_u (.*);

   always #2.5 clk = ~clk;

   task automatic chk(input bit ok, input string what);
      checked++;
      if (!ok) begin
         mismatches++;
         $display("BAD %0t %s", $time, what);
      end
   endtask

   task automatic report_and_stop();
      if (mismatches == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // High bit set keeps filler bytes clear of both delimiters
   function automatic logic [7:0] rnd();
      return 8'($urandom) | 8'h80;
   endfunction

   // Note the expected output (e: kept, last), then offer the byte
   task automatic sendx(input logic [7:0] b, input logic [1:0] e);
      if (e[1])
         expQ.push_back({e[0], b});
      src_u.put(b);
   endtask

   task automatic settle(input int n);
      int i;
      src_u.rest(n);
      for (i = 0; i < 3000 && expQ.size() != 0; i++) @(posedge clk);
      chk(expQ.size() == 0, "frame missing");
   endtask

   // Random sink stalls; each taken byte is matched to the oldest note
   always @(posedge clk) begin
      txReady <= ($urandom % 4) != 0;
      cycles++;
      if (connClose === 1'b1)
         closes++;
      if (txValid === 1'b1 && txReady) begin
         if (expQ.size() == 0)
            chk(1'b0, "unexpected byte");
         else
            chk({txLast, txData} === expQ.pop_front(), "byte");
      end
      if (cycles == 20000) begin
         mismatches++;
         report_and_stop();
      end
   end

   initial begin
      int m, k, n;
      void'($urandom(60884));
      delimMode = serial_packet_framer_pkg::DELIM_KEEP;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      repeat (2) @(posedge clk);
      // Every delimiter handling option with one delimiter
      for (m = 0; m < 4; m++) begin
         delimMode <= serial_packet_framer_pkg::delim_mode_type'(m[1:0]);
         n = (m == 1) ? 1 : (m == 2) ? 2 : 0;
         @(posedge clk);
         sendx(rnd(), 2'b10);
         sendx(rnd(), {1'b1, m == 3});
         sendx(8'h0d, {m != 3, m == 0});
         for (k = 1; k <= n; k++) sendx(rnd(), {1'b1, k == n});
         settle(4);
      end
      // Stripped pair, with a lone first delimiter kept in the data
      delim2En <= 1'b1;
      @(posedge clk);
      sendx(rnd(), 2'b10);
      sendx(8'h0d, 2'b10);
      sendx(rnd(), 2'b11);
      sendx(8'h0d, 2'b00);
      sendx(8'h0a, 2'b00);
      settle(4);
      // Fixed length release at one and three bytes
      delim1En <= 1'b0;
      delim2En <= 1'b0;
      for (n = 1; n <= 3; n += 2) begin
         packLength <= 11'(n);
         @(posedge clk);
         for (k = 1; k <= n; k++) begin
            sendx(8'($urandom), {1'b1, k == n});
         end
         settle(2);
      end
      // Nothing but a full buffer releases now
      packLength <= 11'h000;
      @(posedge clk);
      for (k = 1; k <= 1024; k++) begin
         sendx(8'($urandom), {1'b1, k == 1024});
         if (k == 5) begin
            src_u.rest(30);
            chk(bufLevel === 11'h005 && expQ.size() == 5,
               "held");
         end
      end
      settle(2);
      // Timed release; a 6 ms gap stays inside the 11 ms interval
      flushTimeoutMs <= 16'h000b;
      @(posedge clk);
      sendx(8'($urandom), 2'b10);
      src_u.rest(60);
      sendx(8'($urandom), 2'b11);
      src_u.rest(1);
      for (k = 0; k < 200 && txValid !== 1'b1; k++) @(posedge clk);
      chk(k >= 106 && k <= 118, "flush interval");
      settle(1);
      // Listening port and serial settings source
      for (n = 0; n < 4; n++) begin
         maxConnections <= 4'(n);
         listenPortNumber <= (n == 0) ? 16'h0000 : 16'($urandom);
         localSerialCfg <= 16'($urandom);
         hostSerialCfg <= 16'($urandom);
         repeat (2) @(posedge clk);
         chk(listenPort === ((listenPortNumber == 16'h0000) ? 16'h0fa1
            : listenPortNumber), "port");
         chk(activeSerialCfg === ((n >= 2) ? localSerialCfg : hostSerialCfg),
            "serial cfg");
      end
      // Idle close: nothing while off, then one minute of quiet
      connOpen <= 1'b1;
      repeat (120) @(posedge clk);
      chk(closes == 0, "close while off");
      connectionIdleCheck <= 7'h01;
      netActivity <= 1'b1;
      @(posedge clk);
      netActivity <= 1'b0;
      for (k = 0; k < 100 && connClose !== 1'b1; k++) @(posedge clk);
      chk(k >= 43 && k <= 52, "idle close time");
      report_and_stop();
   end
endmodule

// File: tick_divider.sv
// Counts step events and pulses tick every limit steps.
// Assumes clk, resetn and clkEn shared with the instantiating module.
`timescale 1ns/1ps
module tick_divider #(
   parameter int W = 18
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   input wire logic clkEn,
   // Control
   input wire logic clear,
   input wire logic step,
   input wire logic [W-1:0] limit,
   // Result
   output logic tick
);
   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;
   logic tick_r;
   logic tick_nxt;

   // Clear restarts the period so a caller can align ticks to an event
   always_comb begin
      cnt_nxt = cnt_r;
      tick_nxt = 1'b0;
      if (clear) begin
         cnt_nxt = '0;
      end else if (step) begin
         if (cnt_r >= limit - W'(1)) begin
            cnt_nxt = '0;
            tick_nxt = 1'b1;
         end else begin
            cnt_nxt = cnt_r + W'(1);
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_r <= '0;
         tick_r <= 1'b0;
      end else if (clkEn) begin
         cnt_r <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tick = tick_r;
endmodule
